// ---- logic/mis_top.sv ----
/*
 Interrupt flags, enables, timer, sleep and vector hand-off of a small
 controller, with an APB register slave. Assumes the core obeys irq_take
 (push return address, load pc_vector) and irq_pop on return.
*/
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "mis_map.svh"
module mis_top (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins
   input  wire logic        ext_irq_pin,
   input  wire logic [3:0]  upper_port_pins,
   // Converter
   input  wire logic        conversion_done,
   // Core
   input  wire logic        sleep_enter,
   input  wire logic        return_from_irq_op,
   output logic             irq_req,
   output logic             irq_take,
   output logic             irq_pop,
   output logic [12:0]      pc_vector,
   output logic             wake,
   output logic             asleep
);
   mis_pkg::mis_state_t st_q;
   mis_pkg::mis_state_t st_d;

   logic [4:0]  pins_s;
   logic        ext_s;
   logic        mismatch;
   logic        acc;
   logic        wr;
   logic        port_rd;
   logic        hit;
   logic [31:0] rmux;
   logic        ext_evt;
   logic        tmr_wr;
   logic        tmr_run;
   logic        pending;
   logic        wake_evt;

   ////////////////////////////////////////////////////////////////////////
   // Pin inputs

   mis_pin_sync u_sync (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .pins_async ({upper_port_pins, ext_irq_pin}),
      .pins_sync  (pins_s)
   );

   assign ext_s = pins_s[0];

   mis_port_change u_pc (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .pins     (pins_s[4:1]),
      .dir_in   (st_q.port_dir),
      .reload   (port_rd),
      .mismatch (mismatch)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign port_rd = acc & !pwrite & (paddr == `MIS_OFS_PORT_DATA);
   assign tmr_wr  = wr & (paddr == `MIS_OFS_TMR_CNT);

   always_comb begin
      hit  = 1'b1;
      rmux = '0;
      case (paddr)
         `MIS_OFS_IRQ_CTRL:  rmux[7:0] = st_q.irq_ctrl;
         `MIS_OFS_CONV_CTRL: rmux[7:0] = st_q.conv_ctrl;
         `MIS_OFS_TMR_CFG:   rmux[7:0] = st_q.tmr_cfg;
         `MIS_OFS_PORT_DIR:  rmux[3:0] = st_q.port_dir;
         `MIS_OFS_PORT_DATA: rmux[7:0] = {pins_s[4:1], 3'h0, ext_s};
         `MIS_OFS_TMR_CNT:   rmux[7:0] = st_q.tmr_cnt;
         default:            hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Events and request

   // Edge against last sampled level; polarity picks the edge
   assign ext_evt = st_q.tmr_cfg[`MIS_BIT_EDGE_POL] ?
                    (ext_s & !st_q.ext_prev) :
                    (!ext_s & st_q.ext_prev);

   // Timer stops in sleep, so it cannot raise a wake
   assign tmr_run = (st_q.pwr == mis_pkg::PWR_RUN);

   assign pending =
      (st_q.irq_ctrl[`MIS_BIT_PORT_FLAG] & st_q.irq_ctrl[`MIS_BIT_PORT_EN]) |
      (st_q.irq_ctrl[`MIS_BIT_EXT_FLAG]  & st_q.irq_ctrl[`MIS_BIT_EXT_EN])  |
      (st_q.irq_ctrl[`MIS_BIT_TMR_FLAG]  & st_q.irq_ctrl[`MIS_BIT_TMR_EN])  |
      (st_q.conv_ctrl[`MIS_BIT_CONV_FLAG] & st_q.irq_ctrl[`MIS_BIT_CONV_EN]);

   assign irq_req = st_q.irq_ctrl[`MIS_BIT_GIE] & pending;

   // Pin enable sampled at sleep entry; the port change enable is the live bit
   assign wake_evt = (ext_evt & st_q.ext_en_sleep) |
                     (mismatch & st_q.irq_ctrl[`MIS_BIT_PORT_EN]);

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_d          = st_q;
      st_d.take     = 1'b0;
      st_d.wake     = 1'b0;
      st_d.ext_prev = ext_s;

      // Read data captured in setup so access needs no wait state
      if (psel && !penable) begin
         st_d.prdata  = rmux;
         st_d.pslverr = !hit;
      end

      if (wr) begin
         case (paddr)
            `MIS_OFS_IRQ_CTRL:  st_d.irq_ctrl  = pwdata[7:0];
            `MIS_OFS_CONV_CTRL: st_d.conv_ctrl = pwdata[7:0];
            `MIS_OFS_TMR_CFG:   st_d.tmr_cfg   = pwdata[7:0];
            `MIS_OFS_PORT_DIR:  st_d.port_dir  = pwdata[3:0];
            `MIS_OFS_TMR_CNT:   st_d.tmr_cnt   = pwdata[7:0];
            default:            st_d.pslverr   = st_q.pslverr;
         endcase
      end

      // Timer; a bus write of the count takes priority over counting
      if (tmr_run && !tmr_wr) begin
         st_d.tmr_cnt = st_q.tmr_cnt + 8'h01;
         if (st_q.tmr_cnt == `MIS_TMR_MAX) begin
            st_d.irq_ctrl[`MIS_BIT_TMR_FLAG] = 1'b1;
         end
      end

      // Hardware sets win over a software clear in the same cycle
      if (ext_evt) begin
         st_d.irq_ctrl[`MIS_BIT_EXT_FLAG] = 1'b1;
      end
      if (mismatch) begin
         st_d.irq_ctrl[`MIS_BIT_PORT_FLAG] = 1'b1;
      end
      if (conversion_done) begin
         st_d.conv_ctrl[`MIS_BIT_CONV_FLAG] = 1'b1;
      end

      case (st_q.pwr)
         mis_pkg::PWR_RUN: begin
            if (return_from_irq_op) begin
               st_d.irq_ctrl[`MIS_BIT_GIE] = 1'b1;
            end else if (irq_req && !st_q.take) begin
               st_d.take                   = 1'b1;
               st_d.irq_ctrl[`MIS_BIT_GIE] = 1'b0;
            end else if (sleep_enter) begin
               st_d.pwr          = mis_pkg::PWR_ASLEEP;
               st_d.ext_en_sleep = st_q.irq_ctrl[`MIS_BIT_EXT_EN];
            end
         end
         mis_pkg::PWR_ASLEEP: begin
            // On wake the run state vectors only if global enable is set
            if (wake_evt) begin
               st_d.pwr  = mis_pkg::PWR_RUN;
               st_d.wake = 1'b1;
            end
         end
         default: st_d.pwr = mis_pkg::PWR_RUN;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_q              <= '0;
         st_q.irq_ctrl     <= `MIS_RST_IRQ_CTRL;
         st_q.conv_ctrl    <= `MIS_RST_CONV_CTRL;
         st_q.tmr_cfg      <= `MIS_RST_TMR_CFG;
         st_q.port_dir     <= `MIS_RST_PORT_DIR;
         st_q.pwr          <= mis_pkg::PWR_RUN;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata    = st_q.prdata;
   assign pslverr   = st_q.pslverr & acc;
   assign pready    = 1'b1;
   assign irq_take  = st_q.take;
   assign irq_pop   = return_from_irq_op & (st_q.pwr == mis_pkg::PWR_RUN);
   assign pc_vector = `MIS_IRQ_VECTOR;
   assign wake      = st_q.wake;
   assign asleep    = (st_q.pwr == mis_pkg::PWR_ASLEEP);

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   chk_ext_rise_flag: assert property (
      (ext_s && !st_q.ext_prev && st_q.tmr_cfg[`MIS_BIT_EDGE_POL])
      |=> st_q.irq_ctrl[`MIS_BIT_EXT_FLAG])
      else $error("rising pin edge did not set the pin flag");

   chk_ext_wrong_edge: assert property (
      (!ext_s && st_q.ext_prev && st_q.tmr_cfg[`MIS_BIT_EDGE_POL]
       && !st_q.irq_ctrl[`MIS_BIT_EXT_FLAG] && !wr)
      |=> !st_q.irq_ctrl[`MIS_BIT_EXT_FLAG])
      else $error("falling edge set the pin flag under rising polarity");

   chk_gie_blocks: assert property (
      !st_q.irq_ctrl[`MIS_BIT_GIE] |-> !irq_req ##1 !irq_take)
      else $error("request or take while global enable is clear");

   chk_tmr_rollover: assert property (
      (st_q.tmr_cnt == 8'hFF && tmr_run && !tmr_wr)
      |=> st_q.tmr_cnt == 8'h00 && st_q.irq_ctrl[`MIS_BIT_TMR_FLAG])
      else $error("timer rollover missed or flag not set");

   chk_tmr_sleep_hold: assert property (
      (asleep && !tmr_wr) |=> $stable(st_q.tmr_cnt))
      else $error("timer moved while asleep");

   chk_port_flag_set: assert property (
      mismatch |=> st_q.irq_ctrl[`MIS_BIT_PORT_FLAG])
      else $error("port mismatch did not set the change flag");

   chk_take_vector: assert property (
      (irq_req && !irq_take && !asleep && !return_from_irq_op)
      |=> irq_take && !st_q.irq_ctrl[`MIS_BIT_GIE] ##1 !irq_take)
      else $error("taken interrupt did not pulse once and clear enable");

   chk_return_sets: assert property (
      (return_from_irq_op && !asleep && !wr) |=> st_q.irq_ctrl[`MIS_BIT_GIE])
      else $error("return did not set global enable");

   chk_pin_wake: assert property (
      (asleep && ext_evt && st_q.ext_en_sleep) |=> wake && !asleep)
      else $error("enabled pin edge did not wake");

   chk_wake_vector: assert property (
      (wake && irq_req) |=> irq_take)
      else $error("wake with enabled request did not vector");

   ////////////////////////////////////////////////////////////////////////
   // Checks: flags, masks and sleep

   chk_ext_fall_flag: assert property (
      (!ext_s && st_q.ext_prev && !st_q.tmr_cfg[`MIS_BIT_EDGE_POL])
      |=> st_q.irq_ctrl[`MIS_BIT_EXT_FLAG])
      else $error("falling pin edge did not set the pin flag");

   chk_rise_wrong_edge: assert property (
      (ext_s && !st_q.ext_prev && !st_q.tmr_cfg[`MIS_BIT_EDGE_POL]
       && !st_q.irq_ctrl[`MIS_BIT_EXT_FLAG] && !wr)
      |=> !st_q.irq_ctrl[`MIS_BIT_EXT_FLAG])
      else $error("rising edge set the pin flag under falling polarity");

   // Sticky until a bus write: no hardware path clears a flag
   chk_ext_flag_sticky: assert property (
      (st_q.irq_ctrl[`MIS_BIT_EXT_FLAG] && !wr) |=> st_q.irq_ctrl[`MIS_BIT_EXT_FLAG])
      else $error("pin flag dropped without a write");

   chk_tmr_flag_sticky: assert property (
      (st_q.irq_ctrl[`MIS_BIT_TMR_FLAG] && !wr) |=> st_q.irq_ctrl[`MIS_BIT_TMR_FLAG])
      else $error("timer flag dropped without a write");

   chk_port_flag_sticky: assert property (
      (st_q.irq_ctrl[`MIS_BIT_PORT_FLAG] && !wr) |=> st_q.irq_ctrl[`MIS_BIT_PORT_FLAG])
      else $error("port change flag dropped without a write");

   chk_conv_flag_set: assert property (
      conversion_done |=> st_q.conv_ctrl[`MIS_BIT_CONV_FLAG])
      else $error("conversion done did not set its flag");

   chk_conv_flag_sticky: assert property (
      (st_q.conv_ctrl[`MIS_BIT_CONV_FLAG] && !wr) |=> st_q.conv_ctrl[`MIS_BIT_CONV_FLAG])
      else $error("conversion flag dropped without a write");

   // All four enables off: nothing may reach the core
   chk_all_masked: assert property (
      (st_q.irq_ctrl[`MIS_BIT_CONV_EN:`MIS_BIT_PORT_EN] == 4'h0) |-> !irq_req)
      else $error("request with every source enable clear");

   chk_port_outputs: assert property (
      (st_q.port_dir == 4'h0) |-> !mismatch)
      else $error("mismatch seen with every upper pin an output");

   chk_port_reload: assert property (
      (port_rd ##1 $stable(pins_s[4:1])) |-> !mismatch)
      else $error("port read did not end the mismatch");

   chk_take_from_req: assert property (
      irq_take |-> $past(irq_req))
      else $error("take without a request");

   chk_vector_fixed: assert property (
      irq_take |-> pc_vector == `MIS_IRQ_VECTOR)
      else $error("vector not the fixed entry address");

   chk_no_take_asleep: assert property (
      asleep |=> !irq_take)
      else $error("take issued while asleep");

   // Pin enable frozen at entry, so later writes cannot arm a pin-edge wake
   chk_sleep_en_sample: assert property (
      (!asleep && sleep_enter && !return_from_irq_op && !irq_req)
      |=> asleep && st_q.ext_en_sleep == $past(st_q.irq_ctrl[`MIS_BIT_EXT_EN]))
      else $error("sleep entry missed or pin enable not sampled");

   chk_port_wake: assert property (
      (asleep && mismatch && st_q.irq_ctrl[`MIS_BIT_PORT_EN]) |=> wake && !asleep)
      else $error("enabled port change did not wake");

   // Timer overflow is no wake source: only pin edge or mismatch
   chk_no_wake_source: assert property (
      (asleep && !ext_evt && !mismatch) |=> asleep && !wake)
      else $error("woke with no pin edge and no mismatch");

   chk_wake_no_vector: assert property (
      (wake && !st_q.irq_ctrl[`MIS_BIT_GIE]) |=> !irq_take)
      else $error("vectored after wake with global enable clear");

   cov_take:     cover property (irq_take);
   cov_wake:     cover property (wake);
   cov_rollover: cover property (st_q.tmr_cnt == 8'hFF && tmr_run ##1 st_q.tmr_cnt == 8'h00);
   cov_reload:   cover property (mismatch ##1 port_rd ##2 !mismatch);
   cov_pc_wake:  cover property (asleep && mismatch ##1 wake);
endmodule // mis_top

// ---- logic/mis_map.svh ----
/*
 Register offsets, field positions, reset values and fixed addresses for the
 interrupt source block. Assumes a 32-bit APB with byte addresses on paddr.
*/
// Function
// - External pin edge selected by polarity bit
// - Selected pin edge sets external pin flag
// - External pin enable gates its interrupt
// - External flag sticky until software writes zero
// - Pin edge wakes if enabled at sleep
// - After wake, vector only under global enable
// - Timer rollover FFh to 00h sets flag
// - Timer enable gates; overflow flag stays set
// - Timer never wakes; stopped while asleep
// - Input upper pins compared to latch each cycle
// - Mismatches ORed set port change flag
// - Output pins excluded from mismatch compare
// - Port change mismatch wakes from sleep if its enable is set
// - Port read reloads latch, ends mismatch
// - Port change enable gates its interrupt
// - Conversion done sets flag in converter register
// - Conversion done enable gates its interrupt
// - Global enable gates all; cleared by reset
// - Taking interrupt clears enable, pushes, vectors 0004h
// - Flags set regardless of any enable
// - Return from interrupt pops, sets global enable
`ifndef MIS_MAP_SVH
`define MIS_MAP_SVH

`define MIS_OFS_IRQ_CTRL   8'h00
`define MIS_OFS_CONV_CTRL  8'h04
`define MIS_OFS_TMR_CFG    8'h08
`define MIS_OFS_PORT_DIR   8'h0C
`define MIS_OFS_PORT_DATA  8'h10
`define MIS_OFS_TMR_CNT    8'h14

`define MIS_BIT_PORT_FLAG  0
`define MIS_BIT_EXT_FLAG   1
`define MIS_BIT_TMR_FLAG   2
`define MIS_BIT_PORT_EN    3
`define MIS_BIT_EXT_EN     4
`define MIS_BIT_TMR_EN     5
`define MIS_BIT_CONV_EN    6
`define MIS_BIT_GIE        7
`define MIS_BIT_CONV_FLAG  1
`define MIS_BIT_EDGE_POL   6

`define MIS_RST_IRQ_CTRL   8'h00
`define MIS_RST_CONV_CTRL  8'h00
`define MIS_RST_TMR_CFG    8'h00
`define MIS_RST_PORT_DIR   4'hF
`define MIS_TMR_MAX        8'hFF
`define MIS_IRQ_VECTOR     13'h0004

`endif

// ---- logic/mis_pkg.sv ----
/*
 Types of the interrupt source block: power state and the state records of
 each module. Assumes the constants header is included by the users.
*/
package mis_pkg;

   typedef enum logic {
      PWR_RUN,
      PWR_ASLEEP
   } mis_pwr_t;

   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
   } mis_sync_t;

   typedef struct packed {
      logic [3:0] latch;
   } mis_pc_t;

   typedef struct packed {
      logic [7:0]  irq_ctrl;
      logic [7:0]  conv_ctrl;
      logic [7:0]  tmr_cfg;
      logic [3:0]  port_dir;
      logic [7:0]  tmr_cnt;
      logic        ext_prev;
      mis_pwr_t    pwr;
      logic        ext_en_sleep;
      logic [31:0] prdata;
      logic        pslverr;
      logic        take;
      logic        wake;
   } mis_state_t;

endpackage

// ---- logic/mis_pin_sync.sv ----
/*
 Two-stage synchroniser for the external pin and the four upper port pins.
 Assumes the pins are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module mis_pin_sync (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // Pins in, synchronised copy out
   input  wire logic [4:0] pins_async,
   output logic      [4:0] pins_sync
);
   mis_pkg::mis_sync_t st_q;
   mis_pkg::mis_sync_t st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = pins_async;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pins_sync = st_q.s2;
endmodule // mis_pin_sync

// ---- logic/mis_port_change.sv ----
/*
 Change detector for the four upper port pins: per-pin latch and compare.
 Assumes synchronised pins and a one-cycle reload pulse from a port read.
*/
`timescale 1ns/1ps
module mis_port_change (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // Pins, direction (1 = input) and reload
   input  wire logic [3:0] pins,
   input  wire logic [3:0] dir_in,
   input  wire logic       reload,
   // Result
   output logic            mismatch
);
   mis_pkg::mis_pc_t st_q;
   mis_pkg::mis_pc_t st_d;
   logic [3:0]       miss;

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_bit
         // Driven pins never count as a change
         assign miss[i] = dir_in[i] & (pins[i] ^ st_q.latch[i]);
      end
   endgenerate

   always_comb begin
      st_d = st_q;
      if (reload) begin
         st_d.latch = pins;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign mismatch = |miss;
endmodule // mis_port_change

// ---- bench/mis_core_model.sv ----
/*
 Core model: keeps a return stack, takes the vector, issues sleep and
 return pulses on request. Assumes the block's core-side pulse timing.
*/
`timescale 1ns/1ps
module mis_core_model (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // From the block
   input  wire logic        irq_take,
   input  wire logic        irq_pop,
   input  wire logic [12:0] pc_vector,
   input  wire logic        wake,
   // Requests from the bench
   input  wire logic        go_sleep,
   input  wire logic        go_ret,
   // To the block
   output logic             sleep_enter,
   output logic             return_from_irq_op,
   // Observed state
   output logic [12:0]      pc,
   output logic [3:0]       sp,
   output logic [7:0]       takes,
   output logic [7:0]       wakes
);
   logic [12:0] stk [8];

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sleep_enter        <= 1'b0;
         return_from_irq_op <= 1'b0;
         pc                 <= 13'h0000;
         sp                 <= 4'h0;
         takes              <= 8'h00;
         wakes              <= 8'h00;
      end else begin
         sleep_enter        <= go_sleep;
         return_from_irq_op <= go_ret;
         if (irq_take) begin
            stk[sp[2:0]] <= pc;
            sp           <= sp + 4'h1;
            pc           <= pc_vector;
            takes        <= takes + 8'h01;
         end else if (irq_pop) begin
            pc <= stk[sp[2:0] - 3'h1];
            sp <= sp - 4'h1;
         end else begin
            pc <= pc + 13'h0001;
         end
         if (wake) begin
            wakes <= wakes + 8'h01;
         end
      end
   end
endmodule // mis_core_model

// ---- bench/mis_top_tb.sv ----
/*
 Self-checking bench: APB master, pin and converter stimulus, one task per
 scenario. Assumes mis_top and the core model beside it.
*/
`timescale 1ns/1ps
`include "mis_map.svh"
module mis_top_tb;
   localparam logic [7:0] a_irq  = `MIS_OFS_IRQ_CTRL;
   localparam logic [7:0] a_conv = `MIS_OFS_CONV_CTRL;
   localparam logic [7:0] a_tcfg = `MIS_OFS_TMR_CFG;
   localparam logic [7:0] a_dir  = `MIS_OFS_PORT_DIR;
   localparam logic [7:0] a_port = `MIS_OFS_PORT_DATA;
   localparam logic [7:0] a_tcnt = `MIS_OFS_TMR_CNT;

   logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        ext_irq_pin, conversion_done, sleep_enter, return_from_irq_op;
   logic [3:0]  upper_port_pins;
   logic        irq_req, irq_take, irq_pop, wake, asleep, go_sleep, go_ret;
   logic [12:0] pc_vector;
   int          n_errors, checked;

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   mis_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
      .upper_port_pins(upper_port_pins), .conversion_done(conversion_done),
      .sleep_enter(sleep_enter), .return_from_irq_op(return_from_irq_op),
      .irq_req(irq_req), .irq_take(irq_take), .irq_pop(irq_pop),
      .pc_vector(pc_vector), .wake(wake), .asleep(asleep));

   mis_core_model CORE (.clk_sys(clk_sys), .reset_n(reset_n), .irq_take(irq_take),
      .irq_pop(irq_pop), .pc_vector(pc_vector), .wake(wake), .go_sleep(go_sleep),
      .go_ret(go_ret), .sleep_enter(sleep_enter),
      .return_from_irq_op(return_from_irq_op), .pc(), .sp(), .takes(), .wakes());

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_sys);
      end
      if (n >= 50) begin
         n_errors++;
      end
      r       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdbit(input int b, input logic e);
      apb(1'b0, a_irq, 8'h00);
      chk(r[b], e);
   endtask

   // Pins are asynchronous: allow synchroniser plus flag latency
   task automatic pin(input logic e, input logic [3:0] u);
      @(posedge clk_sys);
      ext_irq_pin     <= e;
      upper_port_pins <= u;
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic core_pulse(input logic s);
      @(posedge clk_sys);
      go_sleep <= s;
      go_ret   <= !s;
      @(posedge clk_sys);
      go_sleep <= 1'b0;
      go_ret   <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      apb(1'b0, a_irq, 8'h00);
      chk(r, 32'h0000_0000);
      apb(1'b0, 8'h40, 8'h00);
      chk(err, 1'b1);
   endtask

   task automatic t_ext;
      pin(1'b1, 4'h0);
      rdbit(1, 1'b0);
      pin(1'b0, 4'h0);
      rdbit(1, 1'b1);
      apb(1'b1, a_irq, 8'h00);
      rdbit(1, 1'b0);
      apb(1'b1, a_tcfg, 8'h40);
      pin(1'b1, 4'h0);
      rdbit(1, 1'b1);
   endtask

   task automatic t_mask;
      apb(1'b1, a_irq, 8'h87);
      @(negedge clk_sys);
      chk(irq_req, 1'b0);
      @(posedge clk_sys);
      conversion_done <= 1'b1;
      @(posedge clk_sys);
      conversion_done <= 1'b0;
      apb(1'b0, a_conv, 8'h00);
      chk(r[1], 1'b1);
      apb(1'b1, a_irq, 8'h80);
      @(negedge clk_sys);
      chk(irq_req, 1'b0);
      apb(1'b1, a_irq, 8'hC0);
      repeat (3) @(posedge clk_sys);
      chk(CORE.takes, 8'h01);
      chk(pc_vector, 13'h0004);
      rdbit(7, 1'b0);
      // Flag cleared before the return, else the interrupt recurs
      apb(1'b1, a_conv, 8'h00);
      core_pulse(1'b0);
      rdbit(7, 1'b1);
      chk(CORE.sp, 4'h0);
      apb(1'b1, a_irq, 8'h00);
   endtask

   task automatic t_timer;
      apb(1'b1, a_tcnt, 8'h10);
      apb(1'b1, a_irq, 8'h00);
      rdbit(2, 1'b0);
      repeat (250) @(posedge clk_sys);
      rdbit(2, 1'b1);
   endtask

   task automatic t_port;
      apb(1'b1, a_dir, 8'h0E);
      pin(1'b1, 4'h1);
      apb(1'b1, a_irq, 8'h00);
      rdbit(0, 1'b0);
      pin(1'b1, 4'h3);
      rdbit(0, 1'b1);
      apb(1'b1, a_irq, 8'h00);
      rdbit(0, 1'b1);
      apb(1'b0, a_port, 8'h00);
      chk(r, 32'h0000_0031);
      apb(1'b1, a_irq, 8'h00);
      rdbit(0, 1'b0);
      pin(1'b1, 4'h0);
      apb(1'b1, a_dir, 8'h0F);
   endtask

   task automatic t_sleep;
      apb(1'b1, a_irq, 8'h30);
      core_pulse(1'b1);
      repeat (300) @(posedge clk_sys);
      chk(asleep, 1'b1);
      pin(1'b0, 4'h0);
      chk(asleep, 1'b1);
      pin(1'b1, 4'h0);
      chk(CORE.wakes, 8'h01);
      chk(CORE.takes, 8'h01);
      apb(1'b1, a_irq, 8'h08);
      apb(1'b0, a_port, 8'h00);
      core_pulse(1'b1);
      repeat (3) @(posedge clk_sys);
      chk(asleep, 1'b1);
      pin(1'b1, 4'h4);
      chk(CORE.wakes, 8'h02);
      // Wake with global enable set must vector after leaving sleep
      apb(1'b0, a_port, 8'h00);
      pin(1'b0, 4'h4);
      apb(1'b1, a_irq, 8'h90);
      core_pulse(1'b1);
      repeat (3) @(posedge clk_sys);
      chk(asleep, 1'b1);
      pin(1'b1, 4'h4);
      chk(CORE.wakes, 8'h03);
      chk(CORE.takes, 8'h02);
   endtask

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      n_errors = 0;
      checked = 0;
      reset_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {ext_irq_pin, upper_port_pins, conversion_done, go_sleep, go_ret} = '0;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_reset;
      t_ext;
      t_mask;
      t_timer;
      t_port;
      t_sleep;
      results;
   end

   // Whole run is near 800 cycles; this cuts a hang short
   initial begin
      #(40 * 20000);
      n_errors++;
      results;
   end
endmodule // mis_top_tb
